// *** logic/bdm_pkg.sv ***
// package for the background debug command unit
// assumes commands arrive already deframed from the serial link
package bdm_pkg;

  // command codes, chosen locally; link framing is decoded upstream
  typedef enum logic [3:0] {
    null_cmd              = 4'h0,
    read_data_reg_cmd     = 4'h1,
    read_addr_reg_cmd     = 4'h2,
    write_data_reg_cmd    = 4'h3,
    write_addr_reg_cmd    = 4'h4,
    read_control_reg_cmd  = 4'h5,
    write_control_reg_cmd = 4'h6,
    mem_read_cmd          = 4'h7,
    mem_write_cmd         = 4'h8,
    block_dump_cmd        = 4'h9,
    block_fill_cmd        = 4'ha,
    resume_cmd            = 4'hb,
    patch_call_cmd        = 4'hc,
    periph_reset_cmd      = 4'hd
  } cmd_e;

  // operand sizes
  typedef enum logic [1:0] {
    sz_byte = 2'h0,
    sz_word = 2'h1,
    sz_long = 2'h2
  } size_e;

  // operations handed to the core
  typedef enum logic [2:0] {
    op_none   = 3'h0,
    op_reg_rd = 3'h1,
    op_reg_wr = 3'h2,
    op_ctl_rd = 3'h3,
    op_ctl_wr = 3'h4,
    op_resume = 3'h5,
    op_call   = 3'h6
  } core_op_e;

  typedef struct packed {
    cmd_e        cmd;
    size_e       size;
    logic [3:0]  sel;   // register number
    logic [31:0] addr;
    logic [31:0] data;
  } cmd_s;

  typedef struct packed {
    core_op_e    op;
    logic        is_addr; // 1: address register, 0: data register
    logic [3:0]  sel;
    logic [31:0] data;
  } core_req_s;

  typedef struct packed {
    logic        write;
    size_e       size;
    logic [2:0]  space;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_req_s;

  localparam int          RST_CYCLES  = 512;
  localparam int          RST_CNT_W   = 10;
  localparam logic [31:0] PUSH_BYTES  = 32'h4;
  localparam logic [2:0]  STACK_SPACE = 3'h5; // supervisor data

  // bytes moved by one transfer of the given size
  function automatic logic [31:0] size_bytes(input size_e s);
    case (s)
      sz_byte: size_bytes = 32'h1;
      sz_word: size_bytes = 32'h2;
      default: size_bytes = 32'h4;
    endcase
  endfunction

endpackage

// *** logic/bdm_reset_pulse.sv ***
// peripheral reset pulse of fixed length
// assumes start is a one-cycle pulse on sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module bdm_reset_pulse
  import bdm_pkg::*;
#(
  parameter int CYCLES = RST_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      active_o,
  output logic      done_o
);

  logic [RST_CNT_W-1:0] cnt_r;   // cycles left
  logic [RST_CNT_W:0]   len_r;   // helper: cycles seen high

  ////////////////////////////////////////////////////////////////
  // count down; the core keeps running, only the line is driven
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r    <= '0;
      active_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !active_o) begin
        cnt_r    <= RST_CNT_W'(CYCLES - 1);
        active_o <= 1'b1;
      end else if (active_o) begin
        if (cnt_r == '0) begin
          active_o <= 1'b0;
          done_o   <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  // helper counter for the length check
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len_r <= '0;
    end else begin
      len_r <= active_o ? len_r + 1'b1 : '0;
    end
  end

  property p_rst_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(active_o) |-> len_r == (RST_CNT_W+1)'(CYCLES);
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("peripheral reset length wrong");

  // the line must rise at once and stay up, not just blip
  property p_rst_start;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    start_i |=> active_o [*8];
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("peripheral reset not driven");

endmodule
`default_nettype wire

// *** logic/bdm_block_addr.sv ***
// running address for block dump and fill
// assumes load and step never coincide
`timescale 1ns/10ps
`default_nettype none
module bdm_block_addr
  import bdm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_i,   // read or write done
  input  wire logic        load_wr_i,
  input  wire logic        step_i,   // dump or fill done
  input  wire logic [31:0] addr_i,
  input  wire size_e       size_i,
  output logic [31:0]      addr_o,
  output logic             dump_ok_o,
  output logic             fill_ok_o
);

  ////////////////////////////////////////////////////////////////
  // next address is one operand past the last one used
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o    <= '0;
      dump_ok_o <= 1'b0;
      fill_ok_o <= 1'b0;
    end else if (load_i) begin
      addr_o    <= addr_i + size_bytes(size_i);
      dump_ok_o <= !load_wr_i;
      fill_ok_o <= load_wr_i;
    end else if (step_i) begin
      addr_o <= addr_o + size_bytes(size_i);
    end
  end

  // a completed read or write leaves the address one operand on
  property p_blk_step;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    load_i |=> addr_o == $past(addr_i) + size_bytes($past(size_i));
  endproperty
  a_blk_step: assert property (p_blk_step)
    else $error("block address not advanced");

endmodule
`default_nettype wire

// *** logic/bdm_cmd_unit.sv ***
// background debug command interpreter
// assumes deframed commands on cmd_i and same-clock core and bus ports
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - register read returns register contents to host
// - register write loads operand into named register
// - control register read returns selected register
// - control register write stores operand
// - memory read uses source space code
// - memory write uses destination space code
// - read starts a dump, dump reads next
// - write starts a fill, fill writes next
// - resume flushes pipe, continues at current PC
// - call pushes PC at stack, runs patch
// - peripheral reset drives line 512 cycles
// - null command changes nothing
module bdm_cmd_unit
  import bdm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire cmd_s        cmd_i,
  output logic             cmd_ready_o,
  output logic             resp_valid_o,
  output logic             resp_err_o,
  output logic [31:0]      resp_data_o,
  output logic             core_req_valid_o,
  output core_req_s        core_req_o,
  input  wire logic        core_ack_i,
  input  wire logic [31:0] core_rdata_i,
  input  wire logic [31:0] pc_i,
  input  wire logic [31:0] sp_i,
  input  wire logic [2:0]  src_space_i,   // source_space_code_reg
  input  wire logic [2:0]  dst_space_i,   // dest_space_code_reg
  output logic             mem_req_valid_o,
  output mem_req_s         mem_req_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             periph_reset_o
);

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_core  = 3'h1,
    st_mem   = 3'h2,
    st_push  = 3'h3,
    st_reset = 3'h4
  } state_e;

  state_e      state_r;    // sequencer state
  state_e      state_nxt;
  cmd_s        cmd_r;      // command in progress
  logic        acc;        // command taken this cycle
  logic        fin;        // command finishes this cycle
  logic        fin_err;    // finishes with refusal
  logic [31:0] fin_data;   // data returned on finish
  logic [31:0] blk_addr;   // next block address
  logic        dump_ok;    // a read opened a dump
  logic        fill_ok;    // a write opened a fill
  logic        rst_done;   // reset pulse over
  logic        blk_load;
  logic        blk_step;

  assign acc = cmd_valid_i && cmd_ready_o;

  ////////////////////////////////////////////////////////////////
  // next state and completion
  always_comb begin
    state_nxt = state_r;
    fin       = 1'b0;
    fin_err   = 1'b0;
    fin_data  = '0;
    case (state_r)
      st_idle: begin
        if (acc) begin
          case (cmd_i.cmd)
            mem_read_cmd,
            mem_write_cmd: state_nxt = st_mem;
            block_dump_cmd,
            block_fill_cmd: begin
              // refuse a run that no read or write has opened
              if ((cmd_i.cmd == block_dump_cmd) ? dump_ok : fill_ok) begin
                state_nxt = st_mem;
              end else begin
                fin     = 1'b1;
                fin_err = 1'b1;
              end
            end
            patch_call_cmd:   state_nxt = st_push;
            periph_reset_cmd: state_nxt = st_reset;
            null_cmd:         fin = 1'b1;
            default:          state_nxt = st_core;
          endcase
        end
      end
      st_core: begin
        if (core_ack_i) begin
          fin       = 1'b1;
          fin_data  = core_rdata_i;
          state_nxt = st_idle;
        end
      end
      st_mem: begin
        if (mem_ack_i) begin
          fin       = 1'b1;
          fin_data  = mem_rdata_i;
          state_nxt = st_idle;
        end
      end
      st_push: begin
        // stack written, now hand the jump to the core
        if (mem_ack_i) begin
          state_nxt = st_core;
        end
      end
      st_reset: begin
        if (rst_done) begin
          fin       = 1'b1;
          state_nxt = st_idle;
        end
      end
      default: state_nxt = st_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // sequencer and held command; ready only when idle, since one
  // command at a time keeps the answer order simple
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= st_idle;
      cmd_r       <= '0;
      cmd_ready_o <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cmd_ready_o <= (state_nxt == st_idle) && !acc;
      if (acc) begin
        cmd_r <= cmd_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // answer to the host, one-cycle pulse
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_err_o   <= 1'b0;
      resp_data_o  <= '0;
    end else begin
      resp_valid_o <= fin;
      if (fin) begin
        resp_err_o  <= fin_err;
        resp_data_o <= fin_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // core request: held until the core acknowledges
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_req_valid_o <= 1'b0;
      core_req_o       <= '0;
    end else if (acc && state_nxt == st_core) begin
      core_req_valid_o   <= 1'b1;
      core_req_o.sel     <= cmd_i.sel;
      core_req_o.data    <= cmd_i.data;
      core_req_o.is_addr <= (cmd_i.cmd == read_addr_reg_cmd) ||
                            (cmd_i.cmd == write_addr_reg_cmd);
      case (cmd_i.cmd)
        read_data_reg_cmd,
        read_addr_reg_cmd:     core_req_o.op <= op_reg_rd;
        write_data_reg_cmd,
        write_addr_reg_cmd:    core_req_o.op <= op_reg_wr;
        read_control_reg_cmd:  core_req_o.op <= op_ctl_rd;
        write_control_reg_cmd: core_req_o.op <= op_ctl_wr;
        resume_cmd:            core_req_o.op <= op_resume;
        default:               core_req_o.op <= op_none;
      endcase
    end else if (state_r == st_push && mem_ack_i) begin
      // core drops sp by four and jumps to the patch address
      core_req_valid_o <= 1'b1;
      core_req_o.op    <= op_call;
      core_req_o.data  <= cmd_r.data;
    end else if (core_ack_i) begin
      core_req_valid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus request: held until the bus acknowledges
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_req_valid_o <= 1'b0;
      mem_req_o       <= '0;
    end else if (acc && state_nxt == st_mem) begin
      mem_req_valid_o <= 1'b1;
      mem_req_o.size  <= cmd_i.size;
      mem_req_o.data  <= cmd_i.data;
      // block commands carry no address; they use the running one
      mem_req_o.addr  <= (cmd_i.cmd == mem_read_cmd ||
                          cmd_i.cmd == mem_write_cmd) ?
                         cmd_i.addr : blk_addr;
      case (cmd_i.cmd)
        mem_read_cmd,
        block_dump_cmd: begin
          mem_req_o.write <= 1'b0;
          mem_req_o.space <= src_space_i;
        end
        default: begin
          mem_req_o.write <= 1'b1;
          mem_req_o.space <= dst_space_i;
        end
      endcase
    end else if (acc && state_nxt == st_push) begin
      mem_req_valid_o <= 1'b1;
      mem_req_o.write <= 1'b1;
      mem_req_o.size  <= sz_long;
      mem_req_o.space <= STACK_SPACE;
      mem_req_o.addr  <= sp_i - PUSH_BYTES;
      mem_req_o.data  <= pc_i;
    end else if (mem_ack_i) begin
      mem_req_valid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // block address bookkeeping
  assign blk_load = (state_r == st_mem) && mem_ack_i &&
                    ((cmd_r.cmd == mem_read_cmd) ||
                     (cmd_r.cmd == mem_write_cmd));
  assign blk_step = (state_r == st_mem) && mem_ack_i && !blk_load;

  bdm_block_addr u_blk (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (blk_load),
    .load_wr_i (cmd_r.cmd == mem_write_cmd),
    .step_i    (blk_step),
    .addr_i    (mem_req_o.addr),
    .size_i    (cmd_r.size),
    .addr_o    (blk_addr),
    .dump_ok_o (dump_ok),
    .fill_ok_o (fill_ok)
  );

  // core is not reset; only the external line is driven
  bdm_reset_pulse #(
    .CYCLES (RST_CYCLES)
  ) u_rst (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (acc && cmd_i.cmd == periph_reset_cmd),
    .active_o  (periph_reset_o),
    .done_o    (rst_done)
  );

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_reg_rd;
    (state_r == st_core) && core_ack_i && (core_req_o.op == op_reg_rd)
      |=> resp_valid_o && resp_data_o == $past(core_rdata_i);
  endproperty
  a_reg_rd: assert property (p_reg_rd)
    else $error("register read data not returned");
  property p_reg_wr;
    acc && cmd_i.cmd == write_data_reg_cmd |=> core_req_valid_o &&
      core_req_o.op == op_reg_wr && !core_req_o.is_addr &&
      core_req_o.data == $past(cmd_i.data);
  endproperty
  a_reg_wr: assert property (p_reg_wr)
    else $error("register write not issued");
  property p_ctl_rd;
    acc && cmd_i.cmd == read_control_reg_cmd
      |=> core_req_o.op == op_ctl_rd && core_req_o.sel == $past(cmd_i.sel);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("control read not issued");
  property p_ctl_wr;
    acc && cmd_i.cmd == write_control_reg_cmd
      |=> core_req_o.op == op_ctl_wr && core_req_o.data == $past(cmd_i.data);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr)
    else $error("control write not issued");
  property p_mem_rd;
    acc && cmd_i.cmd == mem_read_cmd |=> mem_req_valid_o &&
      !mem_req_o.write && mem_req_o.space == $past(src_space_i) &&
      mem_req_o.addr == $past(cmd_i.addr);
  endproperty
  a_mem_rd: assert property (p_mem_rd)
    else $error("memory read wrong space or address");
  property p_mem_wr;
    acc && cmd_i.cmd == mem_write_cmd |=> mem_req_valid_o &&
      mem_req_o.write && mem_req_o.space == $past(dst_space_i);
  endproperty
  a_mem_wr: assert property (p_mem_wr)
    else $error("memory write wrong space");
  property p_dump_addr;
    acc && cmd_i.cmd == block_dump_cmd && dump_ok
      |=> !mem_req_o.write && mem_req_o.addr == $past(blk_addr);
  endproperty
  a_dump_addr: assert property (p_dump_addr)
    else $error("dump not at block address");
  property p_fill_ref;
    acc && cmd_i.cmd == block_fill_cmd && !fill_ok
      |=> resp_valid_o && resp_err_o && !mem_req_valid_o;
  endproperty
  a_fill_ref: assert property (p_fill_ref)
    else $error("unopened fill not refused");
  property p_resume;
    acc && cmd_i.cmd == resume_cmd |=> core_req_o.op == op_resume;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume not issued");
  property p_call_push;
    acc && cmd_i.cmd == patch_call_cmd |=> mem_req_o.write &&
      mem_req_o.addr == $past(sp_i) - PUSH_BYTES &&
      mem_req_o.data == $past(pc_i);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call did not push pc");
  property p_null;
    acc && cmd_i.cmd == null_cmd |=> resp_valid_o && !resp_err_o &&
      state_r == st_idle && !core_req_valid_o && !mem_req_valid_o;
  endproperty
  a_null: assert property (p_null)
    else $error("null command changed state");

endmodule
`default_nettype wire

// *** bench/bdm_core_model.sv ***
// core and system bus model facing the command unit
// assumes requests are held until acknowledged; acks are one cycle wide
`timescale 1ns/10ps
`default_nettype none
module bdm_core_model
  import bdm_pkg::*;
(
  input  wire logic      sys_clk_i,
  input  wire logic      slow_i,         // 1: answer three cycles late
  input  wire logic      core_req_valid_i,
  input  wire core_req_s core_req_i,
  input  wire logic      mem_req_valid_i,
  input  wire mem_req_s  mem_req_i,
  output logic           core_ack_o,
  output logic [31:0]    core_rdata_o,
  output logic           mem_ack_o,
  output logic [31:0]    mem_rdata_o
);
  logic [31:0] regs [32];           // data regs 0..15, address regs 16..31
  logic [31:0] ctl [16];            // control registers
  logic [31:0] mem [logic [34:0]];  // keyed by space and address
  logic [31:0] call_pc;             // patch entry handed over
  int          resumes;             // resume requests seen
  int          acts;                // core and bus requests seen
  mem_req_s    last;                // last bus request

  ////////////////////////////////////////////////////////////////////////
  // core side: read data is scrambled outside the ack cycle so that a
  // late sample of it can never pass by luck
  initial begin
    core_ack_o = 1'b0;
    core_rdata_o = 32'h0;
    resumes = 0;
    acts = 0;
    forever begin
      @(posedge sys_clk_i);
      if (core_req_valid_i === 1'b1) begin
        repeat (slow_i ? 3 : 0) @(posedge sys_clk_i);
        #1;
        acts++;
        case (core_req_i.op)
          op_reg_rd: core_rdata_o = regs[{core_req_i.is_addr, core_req_i.sel}];
          op_reg_wr: regs[{core_req_i.is_addr, core_req_i.sel}] = core_req_i.data;
          op_ctl_rd: core_rdata_o = ctl[core_req_i.sel];
          op_ctl_wr: ctl[core_req_i.sel] = core_req_i.data;
          op_resume: resumes++;
          op_call:   call_pc = core_req_i.data;
          default:   core_rdata_o = ~core_rdata_o;
        endcase
        core_ack_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        core_ack_o = 1'b0;
        core_rdata_o = ~core_rdata_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus side: unwritten places read back as the inverted address
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h0;
    forever begin
      @(posedge sys_clk_i);
      if (mem_req_valid_i === 1'b1) begin
        repeat (slow_i ? 3 : 0) @(posedge sys_clk_i);
        #1;
        acts++;
        last = mem_req_i;
        if (mem_req_i.write)
          mem[{mem_req_i.space, mem_req_i.addr}] = mem_req_i.data;
        else if (mem.exists({mem_req_i.space, mem_req_i.addr}))
          mem_rdata_o = mem[{mem_req_i.space, mem_req_i.addr}];
        else
          mem_rdata_o = ~mem_req_i.addr;
        mem_ack_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        mem_ack_o = 1'b0;
        mem_rdata_o = ~mem_rdata_o;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/background_debug_command_unit_bench.sv ***
// self-checking bench for the background debug command unit
// assumes the core and bus model answers every request
`timescale 1ns/10ps
`default_nettype none
module background_debug_command_unit_bench;
  import bdm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i, cmd_valid_i, slow, cmd_ready, resp_valid, resp_err;
  logic core_req_valid, core_ack, mem_req_valid, mem_ack, periph;
  logic [31:0] resp_data, core_rdata, mem_rdata, pc, sp;
  logic [31:0] got_data, v, d, a, p [3];
  logic [2:0]  src, dst;
  logic        got_err;
  cmd_s        cmd_i;
  core_req_s   core_req;
  mem_req_s    mem_req;
  int          err_count, tests_run, cycles, rst_hi, n0;
  logic [31:0] seed = 32'd58462;  // fixed so runs repeat

  always #2 sys_clk_i = ~sys_clk_i;

  bdm_cmd_unit i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready),
    .resp_valid_o(resp_valid), .resp_err_o(resp_err),
    .resp_data_o(resp_data), .core_req_valid_o(core_req_valid),
    .core_req_o(core_req), .core_ack_i(core_ack),
    .core_rdata_i(core_rdata), .pc_i(pc), .sp_i(sp), .src_space_i(src),
    .dst_space_i(dst), .mem_req_valid_o(mem_req_valid),
    .mem_req_o(mem_req), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .periph_reset_o(periph));

  bdm_core_model i_model (.sys_clk_i(sys_clk_i), .slow_i(slow),
    .core_req_valid_i(core_req_valid), .core_req_i(core_req),
    .mem_req_valid_i(mem_req_valid), .mem_req_i(mem_req),
    .core_ack_o(core_ack), .core_rdata_o(core_rdata),
    .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

  ////////////////////////////////////////////////////////////////////////
  // xorshift source; also flips the model between prompt and slow
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // bytes stepped per transfer, worked out here on purpose
  function automatic logic [31:0] step(input size_e s);
    return (s == sz_byte) ? 32'h1 : (s == sz_word) ? 32'h2 : 32'h4;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one command, held until taken, then wait for its answer; counts
  // cycles with the reset line high on the way
  task automatic send(input cmd_e c, input size_e s, input logic [3:0] sel,
                      input logic [31:0] ad, input logic [31:0] dt);
    int n;
    logic [31:0] r;
    r = rnd();
    slow = r[0];
    rst_hi = 0;
    n0 = i_model.acts;
    cmd_i = '{cmd: c, size: s, sel: sel, addr: ad, data: dt};
    cmd_valid_i = 1'b1;
    do @(posedge sys_clk_i); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid_i = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 1000) begin
      if (periph === 1'b1)
        rst_hi++;
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 1000)
      check(1'b0, 1'b1);
    got_data = resp_data;
    got_err = resp_err;
    @(posedge sys_clk_i);
    #1;
  endtask

  // timeout guard, far above the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    slow = 1'b0;
    pc = 32'h0;
    sp = 32'h0;
    src = 3'h1;
    dst = 3'h2;
    repeat (20) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    check(cmd_ready, 1'b1);
    check(periph, 1'b0);
    // dump and fill refused before any block is opened
    send(block_dump_cmd, sz_long, 4'h0, 32'h0, 32'h0);
    check(got_err, 1'b1);
    send(block_fill_cmd, sz_long, 4'h0, 32'h0, 32'h0);
    check(got_err, 1'b1);
    check(i_model.acts, n0);
    $display("test refuse done");
    // data and address registers, written then read back
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      v = rnd();
      send(i[0] ? write_addr_reg_cmd : write_data_reg_cmd, sz_long,
           {1'b0, v[2:0]}, 32'h0, d);
      check(i_model.regs[{i[0], 1'b0, v[2:0]}], d);
      send(i[0] ? read_addr_reg_cmd : read_data_reg_cmd, sz_long,
           {1'b0, v[2:0]}, 32'h0, 32'h0);
      check(got_data, d);
    end
    $display("test registers done");
    // control registers, three random selectors and the last one
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      a = (i == 3) ? 32'hf : {28'h0, d[7:4]};
      send(write_control_reg_cmd, sz_long, a[3:0], 32'h0, d);
      check(i_model.ctl[a[3:0]], d);
      send(read_control_reg_cmd, sz_long, a[3:0], 32'h0, 32'h0);
      check(got_data, d);
    end
    $display("test control done");
    // null changes nothing and answers without error
    send(null_cmd, sz_long, 4'h0, 32'h0, 32'h0);
    check(i_model.acts, n0);
    check(got_err, 1'b0);
    $display("test null done");
    // sized write, fill run, dump refused; read, dump run, fill refused
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      src = v[2:0];
      dst = v[5:3];
      a = {v[31:8], 8'h00};
      d = (k == 0) ? {24'h0, v[15:8]} : (k == 1) ? {16'h0, v[23:8]} : v;
      send(mem_write_cmd, size_e'(k), 4'h0, a, d);
      check(i_model.mem[{dst, a}], d);
      check({i_model.last.write, i_model.last.size}, {1'b1, 2'(k)});
      for (int j = 1; j < 3; j++) begin
        send(block_fill_cmd, size_e'(k), 4'h0, 32'h0, d ^ j);
        check(i_model.mem[{dst, a + j * step(size_e'(k))}], d ^ j);
      end
      send(block_dump_cmd, size_e'(k), 4'h0, 32'h0, 32'h0);
      check(got_err, 1'b1);
      for (int j = 0; j < 3; j++) begin
        p[j] = rnd() & ((k == 0) ? 32'hff : (k == 1) ? 32'hffff : '1);
        i_model.mem[{src, a + j * step(size_e'(k))}] = p[j];
      end
      send(mem_read_cmd, size_e'(k), 4'h0, a, 32'h0);
      check(got_data, p[0]);
      check(i_model.last.space, src);
      for (int j = 1; j < 3; j++) begin
        send(block_dump_cmd, size_e'(k), 4'h0, 32'h0, 32'h0);
        check(got_data, p[j]);
      end
      send(block_fill_cmd, size_e'(k), 4'h0, 32'h0, 32'h0);
      check(got_err, 1'b1);
    end
    $display("test memory done");
    // resume and patch call
    d = i_model.resumes;
    send(resume_cmd, sz_long, 4'h0, 32'h0, 32'h0);
    check(i_model.resumes, d + 32'h1);
    pc = rnd();
    v = rnd();
    sp = {v[31:2], 2'b00};
    d = rnd();
    send(patch_call_cmd, sz_long, 4'h0, 32'h0, d);
    check(i_model.mem[{STACK_SPACE, sp - 32'h4}], pc);
    check(i_model.call_pc, d);
    $display("test resume and call done");
    // peripheral reset pulse length
    send(periph_reset_cmd, sz_long, 4'h0, 32'h0, 32'h0);
    check(rst_hi, RST_CYCLES);
    check(periph, 1'b0);
    $display("test periph reset done");
    final_report();
  end
endmodule
`default_nettype wire
